// ---- verification/host_priority_interrupt_unit_test.sv ----
`timescale 1ns/1ps
module host_priority_interrupt_unit_test;
    logic clk;
    logic rst_b;
    hpiu_pkg::hpiu_io_req_t req;
    logic [7:0] rdata, vec, src;
    logic master, intack, irq, nmi, disk_byte_request, gate, busy;
    logic [3:0] cdata_in, cdata_out, cctrl, delay;
    logic [15:0] haddr;
    int taken;
    int failures = 0;
    int samples_checked = 0;

    hpiu_top dut (
        .MCLK_IN(clk), .RST_B_IN(rst_b), .IO_REQ_IN(req), .IO_RDATA_OUT(rdata),
        .MASTER_EN_IN(master), .INTACK_IN(intack), .INT_OUT(irq), .VECTOR_OUT(vec),
        .NMI_OUT(nmi), .SRC_REQ_IN(src), .DISK_BYTE_REQUEST_IN(disk_byte_request),
        .DISK_IRQ_GATE_BIT_IN(gate), .CLK_DATA_IN(cdata_in), .CLK_BUSY_IN(busy),
        .CLK_DATA_OUT(cdata_out), .CLK_CTRL_OUT(cctrl)
    );

    hpiu_host_model host (
        .clk_in(clk), .rst_b_in(rst_b), .int_in(irq), .vector_in(vec),
        .ack_delay_in(delay), .intack_out(intack), .handler_addr_out(haddr),
        .taken_out(taken)
    );

    // 20 mhz system clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic give_verdict();
        $display("comparisons %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        samples_checked++;
        if (seen !== want) begin
            failures++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    endtask : check

    // one-cycle strobe launched and dropped on falling edges; read data lands in between
    task automatic io(input logic rd, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        req = {rd, ~rd, a, d};
        @(negedge clk);
        req = '0;
    endtask : io

    task automatic rearm();
        io(1'b0, 8'hc0, 8'h10);
    endtask : rearm

    // held three cycles so the synchroniser surely sees the rising edge
    task automatic pulse(input logic [7:0] m);
        @(negedge clk);
        src = m;
        repeat (3) @(negedge clk);
        src = 8'h00;
    endtask : pulse

    task automatic expect_irq(input logic [7:0] v);
        int n0;
        n0 = taken;
        for (int i = 0; i < 40 && taken == n0; i++) @(negedge clk);
        if (taken == n0) begin
            failures++;
            give_verdict();
        end else begin
            check(haddr[7:0], v);
        end
    endtask : expect_irq

    task automatic expect_none();
        int n0;
        n0 = taken;
        repeat (12) @(negedge clk);
        check(8'(taken - n0), 8'h00);
    endtask : expect_none

    task automatic t_reset();
        io(1'b1, 8'h9d, 8'h00);
        check(rdata, 8'h00);
        check({6'h00, irq, nmi}, 8'h00);
        io(1'b0, 8'h9d, 8'ha5);
        io(1'b1, 8'h9d, 8'h00);
        check(rdata, 8'ha5);
        io(1'b1, 8'h50, 8'h00);
        check(rdata, 8'h00);
    endtask : t_reset

    // every source alone, with a growing acknowledge delay
    task automatic t_vectors();
        io(1'b0, 8'h9d, 8'hff);
        for (int i = 0; i < 8; i++) begin
            delay = 4'(i);
            pulse(8'h01 << i);
            expect_irq(8'hf0 + 8'(2 * i));
            rearm();
        end
        delay = 4'h0;
    endtask : t_vectors

    task automatic t_priority();
        pulse(8'h8a);
        expect_irq(8'hf2);
        expect_none();
        rearm();
        expect_irq(8'hf6);
        rearm();
        expect_irq(8'hfe);
        rearm();
        expect_none();
    endtask : t_priority

    task automatic t_enable();
        io(1'b0, 8'h9d, 8'h00);
        pulse(8'h01);
        expect_none();
        io(1'b0, 8'h9d, 8'h01);
        master = 1'b0;
        expect_none();
        master = 1'b1;
        expect_irq(8'hf0);
        rearm();
    endtask : t_enable

    // completion latched while locked out is dropped by a status read
    task automatic t_done_clear();
        io(1'b0, 8'h9d, 8'hff);
        pulse(8'h01);
        expect_irq(8'hf0);
        pulse(8'h10);
        io(1'b1, 8'h94, 8'h00);
        rearm();
        expect_none();
    endtask : t_done_clear

    task automatic t_nmi();
        master = 1'b0;
        @(negedge clk);
        disk_byte_request = 1'b1;
        for (int i = 0; i < 10 && !nmi; i++) @(negedge clk);
        disk_byte_request = 1'b0;
        check({7'h00, nmi}, 8'h01);
        io(1'b1, 8'h94, 8'h00);
        check(rdata, 8'h02);
        // served well inside the byte gap
        io(1'b1, 8'h97, 8'h00);
        repeat (2) @(negedge clk);
        check({7'h00, nmi}, 8'h00);
        io(1'b1, 8'h94, 8'h00);
        check(rdata, 8'h00);
        gate = 1'b0;
        disk_byte_request = 1'b1;
        repeat (8) @(negedge clk);
        disk_byte_request = 1'b0;
        check({7'h00, nmi}, 8'h00);
        master = 1'b1;
        // with the diskette gate off the completion source stays quiet
        pulse(8'h10);
        expect_none();
    endtask : t_nmi

    task automatic t_port();
        io(1'b0, 8'h9f, 8'h91);
        io(1'b1, 8'h9c, 8'h00);
        check({4'h0, rdata[3:0]}, 8'h0a);
        io(1'b0, 8'h9f, 8'h81);
        io(1'b1, 8'h9d, 8'h00);
        check(rdata, 8'h00);
        io(1'b0, 8'h9c, 8'h05);
        check({4'h0, cdata_out}, 8'h05);
        io(1'b0, 8'h9f, 8'h07);
        check({4'h0, cctrl}, 8'h08);
        io(1'b0, 8'h9f, 8'h09);
        check({4'h0, cctrl}, 8'h08);
        busy = 1'b1;
        repeat (3) @(negedge clk);
        io(1'b1, 8'h9e, 8'h00);
        check(rdata, 8'h18);
        io(1'b0, 8'h9f, 8'h06);
        check({4'h0, cctrl}, 8'h00);
    endtask : t_port

    initial begin
        rst_b = 1'b0;
        req = '0;
        master = 1'b1;
        src = 8'h00;
        disk_byte_request = 1'b0;
        gate = 1'b1;
        busy = 1'b0;
        cdata_in = 4'ha;
        delay = 4'h0;
        repeat (5) @(negedge clk);
        rst_b = 1'b1;
        t_reset();
        t_vectors();
        t_priority();
        t_enable();
        t_done_clear();
        t_nmi();
        t_port();
        give_verdict();
    end
endmodule : host_priority_interrupt_unit_test

// ---- verification/hpiu_host_model.sv ----
`timescale 1ns/1ps
// host core: takes the vector after a chosen delay and acknowledges it for one cycle
module hpiu_host_model (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // interrupt from the unit
    input wire logic int_in,
    input wire logic [7:0] vector_in,
    // cycles to sit on a request before taking it
    input wire logic [3:0] ack_delay_in,
    // acknowledge and what the core would call
    output logic intack_out,
    output logic [15:0] handler_addr_out,
    output int taken_out
);
    int wait_cnt;

    // driven off the falling edge so the unit samples a settled acknowledge
    always @(negedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            intack_out <= 1'b0;
            wait_cnt = 0;
            taken_out <= 0;
            handler_addr_out <= 16'h0000;
        end else if (intack_out) begin
            intack_out <= 1'b0;
        end else if (int_in && wait_cnt < int'(ack_delay_in)) begin
            wait_cnt++;
        end else if (int_in) begin
            wait_cnt = 0;
            intack_out <= 1'b1;
            taken_out <= taken_out + 1;
            // table lives on the page at c000h; the offset indexes it
            handler_addr_out <= {8'hc0, vector_in};
        end
    end
endmodule : hpiu_host_model

// ---- verilog/hpiu_pkg.sv ----
package hpiu_pkg;
    // i/o addresses seen by the block
    localparam logic [7:0] ADDR_DISK_STAT = 8'h94;
    localparam logic [7:0] ADDR_DISK_DATA = 8'h97;
    localparam logic [7:0] ADDR_CLK_DATA = 8'h9c;
    localparam logic [7:0] ADDR_SRC_MASK = 8'h9d;
    localparam logic [7:0] ADDR_CLK_CTRL = 8'h9e;
    localparam logic [7:0] ADDR_PORT_CTRL = 8'h9f;
    localparam logic [7:0] ADDR_REARM = 8'hc0;
    // field positions
    localparam int REARM_BIT = 4;
    localparam int CTRL_MODE_BIT = 7;
    localparam int MODE_A_IN_BIT = 4;
    localparam int MODE_B_IN_BIT = 1;
    localparam int DRQ_STAT_BIT = 1;
    localparam int DONE_SRC = 4;
    // reset values
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] MODE_RST = 8'h91;
    localparam logic [3:0] CLK_CTRL_RST = 4'h0;
    localparam logic [3:0] CLK_DATA_RST = 4'h0;
    // vector of the top source; each lower source adds two
    localparam logic [7:0] VEC_BASE = 8'hf0;
    // byte interval of the diskette; software must answer within it
    localparam int DRQ_GAP_NS = 23000;
    localparam int CLK_PERIOD_NS = 50;
    localparam int DRQ_GAP_CYC = DRQ_GAP_NS / CLK_PERIOD_NS;

    // one i/o cycle from the host core
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } hpiu_io_req_t;

    // index of the highest priority request (bit 0 ranks first)
    function automatic logic [2:0] hpiu_pick(input logic [7:0] v);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (v[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction : hpiu_pick

    function automatic logic [7:0] hpiu_vec(input logic [2:0] idx);
        return VEC_BASE | {4'h0, idx, 1'b0};
    endfunction : hpiu_vec
endpackage : hpiu_pkg

// ---- verilog/hpiu_top.sv ----
// Function
// - after interrupting, ignore requests until re-armed
// - latch requests; pick highest pending per re-arm
// - fixed priority, expansion A down to serial
// - vector F0H to FEH by source
// - supply 8-bit table offset when interrupting
// - deliver only if source and master enabled
// - mask is read/write byte at 9DH
// - byte request gated straight to non-maskable line
// - data register access clears byte request
// - mode byte 91H or 81H sets port directions
// - bit-set write sets or clears one port C bit
// - status read or command clears completion interrupt
`timescale 1ns/1ps
module hpiu_top (
    // clock and reset
    input wire logic MCLK_IN,
    input wire logic RST_B_IN,
    // host i/o cycle and read data
    input wire hpiu_pkg::hpiu_io_req_t IO_REQ_IN,
    output logic [7:0] IO_RDATA_OUT,
    // host interrupt handshake
    input wire logic MASTER_EN_IN,
    input wire logic INTACK_IN,
    output logic INT_OUT,
    output logic [7:0] VECTOR_OUT,
    output logic NMI_OUT,
    // source request pins, bit 0 expansion A .. bit 7 serial
    input wire logic [7:0] SRC_REQ_IN,
    // diskette pins
    input wire logic DISK_BYTE_REQUEST_IN,
    input wire logic DISK_IRQ_GATE_BIT_IN,
    // clock chip port pins
    input wire logic [3:0] CLK_DATA_IN,
    input wire logic CLK_BUSY_IN,
    output logic [3:0] CLK_DATA_OUT,
    output logic [3:0] CLK_CTRL_OUT
);
    typedef enum logic [1:0] {ST_ARMED, ST_ASSERT, ST_LOCKED} hpiu_state_t;

    hpiu_state_t state_reg;
    logic [14:0] sync1_reg;
    logic [14:0] sync2_reg;
    logic [8:0] prev_reg;
    logic [7:0] pend_reg;
    logic [7:0] mask_reg;
    logic [7:0] mode_reg;
    logic [2:0] sel_reg;
    logic drq_reg;
    logic int_reg;
    logic [7:0] vec_reg;
    logic [7:0] rdata_reg;
    logic nmi_reg;
    logic [3:0] cdata_reg;
    logic [3:0] cctrl_reg;

    logic [7:0] src_s;
    logic [8:0] rise;
    logic drq_s;
    logic gate_s;
    logic [7:0] eff_mask;
    logic [7:0] elig;
    logic rearm;
    logic stat_acc;
    logic data_acc;
    logic wr_ctrl;

    // two-stage synchronisers; first stage feeds only the second
    always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= {CLK_BUSY_IN, CLK_DATA_IN, DISK_IRQ_GATE_BIT_IN,
                          DISK_BYTE_REQUEST_IN, SRC_REQ_IN};
            sync2_reg <= sync1_reg;
        end
    end

    assign src_s = sync2_reg[7:0];
    assign drq_s = sync2_reg[8];
    assign gate_s = sync2_reg[9];

    // edge history for the request lines
    always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            prev_reg <= '0;
        end else begin
            prev_reg <= sync2_reg[8:0];
        end
    end

    assign rise = sync2_reg[8:0] & ~prev_reg;

    // decode of host i/o cycles
    assign rearm = IO_REQ_IN.wr && IO_REQ_IN.addr == hpiu_pkg::ADDR_REARM
                   && IO_REQ_IN.wdata[hpiu_pkg::REARM_BIT];
    assign stat_acc = (IO_REQ_IN.rd || IO_REQ_IN.wr)
                      && IO_REQ_IN.addr == hpiu_pkg::ADDR_DISK_STAT;
    assign data_acc = (IO_REQ_IN.rd || IO_REQ_IN.wr)
                      && IO_REQ_IN.addr == hpiu_pkg::ADDR_DISK_DATA;
    assign wr_ctrl = IO_REQ_IN.wr && IO_REQ_IN.addr == hpiu_pkg::ADDR_PORT_CTRL;

    // mask drives its sources only while port b is an output
    assign eff_mask = mode_reg[hpiu_pkg::MODE_B_IN_BIT] ? 8'h00 : mask_reg;
    // completion shares the diskette gate with the byte request
    assign elig = pend_reg & eff_mask
                  & {3'h7, gate_s, 4'hf};

    // pending latches: a new edge wins over a clear in the same cycle
    always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            pend_reg <= 8'h00;
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (rise[i]) begin
                    pend_reg[i] <= 1'b1;
                end else if (i == hpiu_pkg::DONE_SRC && stat_acc) begin
                    pend_reg[i] <= 1'b0;
                end else if (state_reg == ST_ASSERT && INTACK_IN && sel_reg == 3'(i)) begin
                    pend_reg[i] <= 1'b0;
                end
            end
        end
    end

    // arm / assert / lock sequencing toward the host
    always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            state_reg <= ST_ARMED;
            int_reg <= 1'b0;
            vec_reg <= hpiu_pkg::VEC_BASE;
            sel_reg <= 3'h0;
        end else begin
            unique case (state_reg)
                ST_ARMED: begin
                    if (MASTER_EN_IN && |elig) begin
                        state_reg <= ST_ASSERT;
                        int_reg <= 1'b1;
                        sel_reg <= hpiu_pkg::hpiu_pick(elig);
                        vec_reg <= hpiu_pkg::hpiu_vec(
                            hpiu_pkg::hpiu_pick(elig));
                    end
                end
                ST_ASSERT: begin
                    if (INTACK_IN) begin
                        state_reg <= ST_LOCKED;
                        int_reg <= 1'b0;
                    end
                end
                ST_LOCKED: begin
                    if (rearm) begin
                        state_reg <= ST_ARMED;
                    end
                end
            endcase
        end
    end

    // byte request flag; access to the data register clears it
    always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            drq_reg <= 1'b0;
        end else if (rise[8]) begin
            drq_reg <= 1'b1;
        end else if (data_acc) begin
            drq_reg <= 1'b0;
        end
    end

    // non-maskable line ignores master enable and the priority chain
    always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            nmi_reg <= 1'b0;
        end else begin
            nmi_reg <= drq_reg && gate_s && !data_acc;
        end
    end

    // port mode byte; a mode write zeroes the output latches
    always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            mode_reg <= hpiu_pkg::MODE_RST;
        end else if (wr_ctrl && IO_REQ_IN.wdata[hpiu_pkg::CTRL_MODE_BIT]) begin
            mode_reg <= IO_REQ_IN.wdata;
        end
    end

    // source mask byte
    always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            mask_reg <= hpiu_pkg::MASK_RST;
        end else if (wr_ctrl && IO_REQ_IN.wdata[hpiu_pkg::CTRL_MODE_BIT]) begin
            mask_reg <= hpiu_pkg::MASK_RST;
        end else if (IO_REQ_IN.wr && IO_REQ_IN.addr == hpiu_pkg::ADDR_SRC_MASK) begin
            mask_reg <= IO_REQ_IN.wdata;
        end
    end

    // clock data latch (low nibble)
    always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            cdata_reg <= hpiu_pkg::CLK_DATA_RST;
        end else if (wr_ctrl && IO_REQ_IN.wdata[hpiu_pkg::CTRL_MODE_BIT]) begin
            cdata_reg <= hpiu_pkg::CLK_DATA_RST;
        end else if (IO_REQ_IN.wr && IO_REQ_IN.addr == hpiu_pkg::ADDR_CLK_DATA) begin
            cdata_reg <= IO_REQ_IN.wdata[3:0];
        end
    end

    // clock control nibble; upper port c bits are inputs, so
    // single-bit writes aimed there are dropped
    always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            cctrl_reg <= hpiu_pkg::CLK_CTRL_RST;
        end else if (wr_ctrl && IO_REQ_IN.wdata[hpiu_pkg::CTRL_MODE_BIT]) begin
            cctrl_reg <= hpiu_pkg::CLK_CTRL_RST;
        end else if (wr_ctrl && !IO_REQ_IN.wdata[3]) begin
            cctrl_reg[IO_REQ_IN.wdata[2:1]] <= IO_REQ_IN.wdata[0];
        end else if (IO_REQ_IN.wr && IO_REQ_IN.addr == hpiu_pkg::ADDR_CLK_CTRL) begin
            cctrl_reg <= IO_REQ_IN.wdata[3:0];
        end
    end

    // registered read data, one cycle after the read strobe
    always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            rdata_reg <= 8'h00;
        end else if (IO_REQ_IN.rd) begin
            unique case (IO_REQ_IN.addr)
                hpiu_pkg::ADDR_CLK_DATA: rdata_reg <= {4'h0,
                    mode_reg[hpiu_pkg::MODE_A_IN_BIT] ? sync2_reg[13:10] : cdata_reg};
                hpiu_pkg::ADDR_SRC_MASK: rdata_reg <= mask_reg;
                hpiu_pkg::ADDR_CLK_CTRL: rdata_reg <= {3'h0, sync2_reg[14], cctrl_reg};
                hpiu_pkg::ADDR_DISK_STAT: rdata_reg <= {6'h0, drq_reg, 1'b0};
                default: rdata_reg <= 8'h00;
            endcase
        end
    end

    assign IO_RDATA_OUT = rdata_reg;
    assign INT_OUT = int_reg;
    assign VECTOR_OUT = vec_reg;
    assign NMI_OUT = nmi_reg;
    assign CLK_DATA_OUT = cdata_reg;
    assign CLK_CTRL_OUT = cctrl_reg;

    // locked unit stays quiet until re-armed
    property p_lock;
        @(posedge MCLK_IN) disable iff (!RST_B_IN)
        (state_reg == ST_LOCKED && !rearm) |=> !int_reg;
    endproperty
    a_lock: assert property (p_lock) else $error("interrupt while locked");

    property p_rearm;
        @(posedge MCLK_IN) disable iff (!RST_B_IN)
        (state_reg == ST_LOCKED && rearm) |=> state_reg == ST_ARMED;
    endproperty
    a_rearm: assert property (p_rearm) else $error("re-arm not taken");

    property p_prio;
        @(posedge MCLK_IN) disable iff (!RST_B_IN)
        $rose(int_reg) |-> vec_reg == hpiu_pkg::hpiu_vec(hpiu_pkg::hpiu_pick($past(elig)));
    endproperty
    a_prio: assert property (p_prio) else $error("wrong source chosen");

    property p_vec;
        @(posedge MCLK_IN) disable iff (!RST_B_IN)
        // the vector is loaded on the same edge that raises the line, so it
        // is only held to be stable from the second cycle on
        int_reg |-> vec_reg[7:4] == 4'hf && !vec_reg[0]
                    && (!$past(int_reg) || $stable(vec_reg));
    endproperty
    a_vec: assert property (p_vec) else $error("vector out of table");

    property p_master;
        @(posedge MCLK_IN) disable iff (!RST_B_IN)
        $rose(int_reg) |-> $past(MASTER_EN_IN) && $past(elig) != 8'h00;
    endproperty
    a_master: assert property (p_master) else $error("interrupt while disabled");

    property p_nmi;
        @(posedge MCLK_IN) disable iff (!RST_B_IN)
        (drq_reg && gate_s && !data_acc) |=> nmi_reg;
    endproperty
    a_nmi: assert property (p_nmi) else $error("byte request not signalled");

    property p_drq_clr;
        @(posedge MCLK_IN) disable iff (!RST_B_IN)
        (data_acc && !rise[8]) |=> !drq_reg ##1 !nmi_reg;
    endproperty
    a_drq_clr: assert property (p_drq_clr) else $error("byte request not cleared");

    property p_done_clr;
        @(posedge MCLK_IN) disable iff (!RST_B_IN)
        (stat_acc && !rise[hpiu_pkg::DONE_SRC]) |=> !pend_reg[hpiu_pkg::DONE_SRC];
    endproperty
    a_done_clr: assert property (p_done_clr) else $error("completion not cleared");

    property p_bitset;
        @(posedge MCLK_IN) disable iff (!RST_B_IN)
        (wr_ctrl && !IO_REQ_IN.wdata[7] && !IO_REQ_IN.wdata[3])
        |=> cctrl_reg[$past(IO_REQ_IN.wdata[2:1])] == $past(IO_REQ_IN.wdata[0]);
    endproperty
    a_bitset: assert property (p_bitset) else $error("port c bit not set");

    property p_mode;
        @(posedge MCLK_IN) disable iff (!RST_B_IN)
        (wr_ctrl && IO_REQ_IN.wdata[7])
        |=> mode_reg == $past(IO_REQ_IN.wdata) && mask_reg == 8'h00;
    endproperty
    a_mode: assert property (p_mode) else $error("mode byte not applied");

endmodule : hpiu_top
